// ### pgc_pkg.sv
package pgc_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [5:0] IDX_BUZZER_CTRL   = 6'h05;
  localparam logic [5:0] IDX_INFRARED_CTRL = 6'h06;
  localparam logic [5:0] IDX_PORT_DATA     = 6'h08;
  localparam logic [5:0] IDX_PORT_DIR      = 6'h09;
  localparam logic [5:0] IDX_PULL_HIGH     = 6'h0A;
  localparam logic [5:0] IDX_PULL_LOW      = 6'h0B;
  localparam logic [5:0] IDX_OPEN_DRAIN    = 6'h0C;
  localparam logic [5:0] IDX_LEVEL_CHG     = 6'h0D;
  localparam logic [5:0] IDX_IRQ_FLAG      = 6'h0E;
  localparam logic [5:0] IDX_IRQ_ENABLE    = 6'h0F;
  localparam logic [5:0] IDX_POWER_CTRL    = 6'h10;
  localparam logic [5:0] IDX_POWER_CTRL1   = 6'h11;

  // Field positions
  localparam int BIT_TONE_EN     = 7;
  localparam int BIT_CARRIER_EN  = 0;
  localparam int BIT_CARRIER_57K = 1;
  localparam int BIT_CARRIER_POL = 2;
  localparam int BIT_PORT_CHG    = 1;
  localparam int BIT_EXT_IRQ_SEL = 6;
  localparam int BIT_GLOBAL_IRQ  = 7;
  localparam int PIN_CARRIER     = 1;
  localparam int PIN_TONE        = 2;
  localparam int PIN_ALWAYS_OD   = 3;

  // Reset values
  localparam logic [3:0] RST_TONE_SEL = 4'hF;
  localparam logic [5:0] RST_PORT_DIR = 6'h3F;

  // Carrier dividers from the 4 MHz input
  localparam int HOSC_KHZ        = 4000;
  localparam int DIV_57K         = 64;
  localparam int DIV_38K         = 96;
  localparam logic [6:0] HALF_57K = 7'(DIV_57K / 2);
  localparam logic [6:0] HALF_38K = 7'(DIV_38K / 2);

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] pull_up;
    logic [5:0] pull_dn;
  } pgc_pad_s;

endpackage

// ### pgc_port_tone_ir.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1: Tone codes 0..7 give the prescaler output divided by 2 up to 256.
// RL2: Tone codes 8..15 follow timer bits 0..7; tone drives pin 2.
// RL3: Tone appears only while its write-only enable is set; reset disables it.
// RL4: Carrier appears on its pin only while its write-only enable is set.
// RL5: Frequency select set gives 57 kHz, clear gives 38 kHz; dividing 4 MHz by 64 or 96 gives 62.5 kHz and about 41.7 kHz instead.
// RL6: Polarity 0 sends carrier while pin data is 1; polarity 1 while 0.
// RL7: Carrier counts a 4 MHz input, dividing by 64 or 96.
// RL8: Carrier counter advances only while the high oscillator runs.
// RL9: Six pins, each read and written via port data, each with direction.
// RL10: Pull-high bits 5..0 act per pin while it is an input.
// RL11: Pull-low bits 7..4 serve pins 3..0; pins 5 and 4 have none.
// RL12: Output pins are open-drain when their open-drain bit is set.
// RL13: Pin 3 always drives open-drain as an output.
// RL14: Level-change select picks pins for change detection; others never set the flag.
// RL15: A change on a selected pin sets the port change flag.
// RL16: Interrupt needs flag, its enable and the global enable all set.
// RL17: External interrupt select routes pin 0 to the external interrupt.
// RL18: With external interrupt on, pin 0 leaves change detection.
// RL19: Enabled carrier is driven onto pin 1.
// RL20: Change flag stays set until software writes 0; new changes win.
module pgc_port_tone_ir #(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [5:0]        i_pin_in,
  output pgc_pkg::pgc_pad_s      o_pad,
  input  wire logic              i_prescaler_out,
  input  wire logic [7:0]        i_timer_val,
  input  wire logic              i_hosc_clk,
  input  wire logic              i_hosc_run,
  output logic                   o_ext_irq_in,
  output logic                   o_irq
);

  // Address decode needs byte address bits 7..2
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("ADDR_W must be at least 8");
  end

  // Word index of a byte address; used for both read and write decode
  function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[7:2];
  endfunction

  function automatic logic index_mapped(input logic [5:0] idx);
    index_mapped = (idx == pgc_pkg::IDX_BUZZER_CTRL) || (idx == pgc_pkg::IDX_INFRARED_CTRL) ||
                   ((idx >= pgc_pkg::IDX_PORT_DATA) && (idx <= pgc_pkg::IDX_POWER_CTRL1));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  logic       tone_en_ff;
  logic [3:0] tone_sel_ff;
  logic       car_en_ff;
  logic       car_57k_ff;
  logic       car_pol_ff;
  logic [5:0] data_ff;
  logic [5:0] dir_ff;
  logic [5:0] pull_high_ff;
  logic [3:0] pull_low_ff;
  logic [5:0] open_drain_ff;
  logic [5:0] chg_sel_ff;
  logic       chg_flag_ff;
  logic       chg_ie_ff;
  logic       ext_sel_ff;
  logic       gie_ff;

  // AXI write and read side holding registers
  logic              aw_got_ff;
  logic              w_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0]       w_data_ff;
  logic              w_strb0_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshakes and decode
  wire       wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  wire [5:0] wr_idx  = word_index(aw_addr_ff);
  wire       wr_en   = wr_fire && w_strb0_ff && index_mapped(wr_idx);
  wire [7:0] wbyte   = w_data_ff[7:0];
  wire       rd_fire = s_axi_arvalid && s_axi_arready;
  wire [5:0] rd_idx  = word_index(s_axi_araddr);

  assign s_axi_awready = !aw_got_ff;
  assign s_axi_wready  = !w_got_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // Write channel capture and response
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= 32'h0000_0000;
      w_strb0_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= pgc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_ff  <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff   <= 1'b1;
        w_data_ff  <= s_axi_wdata;
        w_strb0_ff <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_got_ff   <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= index_mapped(wr_idx) ? pgc_pkg::RESP_OKAY : pgc_pkg::RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin and clock synchronisers
  logic [5:0] pin_s1_ff;
  logic [5:0] pin_s2_ff;
  logic [5:0] pin_prev_ff;
  logic       hosc_s1_ff;
  logic       hosc_s2_ff;
  logic       hosc_prev_ff;
  logic       presc_prev_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_ff     <= 6'h00;
      pin_s2_ff     <= 6'h00;
      pin_prev_ff   <= 6'h00;
      hosc_s1_ff    <= 1'b0;
      hosc_s2_ff    <= 1'b0;
      hosc_prev_ff  <= 1'b0;
      presc_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff     <= i_pin_in;
      pin_s2_ff     <= pin_s1_ff;
      pin_prev_ff   <= pin_s2_ff;
      hosc_s1_ff    <= i_hosc_clk;
      hosc_s2_ff    <= hosc_s1_ff;
      hosc_prev_ff  <= hosc_s2_ff;
      presc_prev_ff <= i_prescaler_out;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data mux; write-only registers read as zero
  wire [7:0] rd_byte =
    (rd_idx == pgc_pkg::IDX_PORT_DATA)   ? {2'h0, pin_s2_ff} :
    (rd_idx == pgc_pkg::IDX_PORT_DIR)    ? {2'h0, dir_ff} :
    (rd_idx == pgc_pkg::IDX_PULL_HIGH)   ? {2'h0, pull_high_ff} :
    (rd_idx == pgc_pkg::IDX_PULL_LOW)    ? {pull_low_ff, 4'h0} :
    (rd_idx == pgc_pkg::IDX_OPEN_DRAIN)  ? {2'h0, open_drain_ff} :
    (rd_idx == pgc_pkg::IDX_LEVEL_CHG)   ? {2'h0, chg_sel_ff} :
    (rd_idx == pgc_pkg::IDX_IRQ_FLAG)    ? {6'h00, chg_flag_ff, 1'b0} :
    (rd_idx == pgc_pkg::IDX_IRQ_ENABLE)  ? {6'h00, chg_ie_ff, 1'b0} :
    (rd_idx == pgc_pkg::IDX_POWER_CTRL)  ? {1'b0, ext_sel_ff, 6'h00} :
    (rd_idx == pgc_pkg::IDX_POWER_CTRL1) ? {gie_ff, 7'h00} : 8'h00;

  // Read channel, one cycle after the address is taken
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= pgc_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= index_mapped(rd_idx) ? pgc_pkg::RESP_OKAY : pgc_pkg::RESP_DECERR;
      rdata_ff  <= {24'h00_0000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Level change detection and port change flag
  wire [5:0] chg_mask = chg_sel_ff & {5'h1F, !ext_sel_ff};                          // RL14 RL18
  wire       chg_any  = |((pin_s2_ff ^ pin_prev_ff) & chg_mask);                    // RL15
  wire       flag_clr = wr_en && (wr_idx == pgc_pkg::IDX_IRQ_FLAG) && !wbyte[pgc_pkg::BIT_PORT_CHG];
  wire       nxt_chg_flag = chg_any || (chg_flag_ff && !flag_clr);                  // RL20

  assign o_irq        = chg_flag_ff && chg_ie_ff && gie_ff;                         // RL16
  assign o_ext_irq_in = ext_sel_ff && pin_s2_ff[0];                                 // RL17

  // Software register writes
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tone_en_ff    <= 1'b0;
      tone_sel_ff   <= pgc_pkg::RST_TONE_SEL;
      car_en_ff     <= 1'b0;
      car_57k_ff    <= 1'b0;
      car_pol_ff    <= 1'b0;
      data_ff       <= 6'h00;
      dir_ff        <= pgc_pkg::RST_PORT_DIR;
      pull_high_ff  <= 6'h00;
      pull_low_ff   <= 4'h0;
      open_drain_ff <= 6'h00;
      chg_sel_ff    <= 6'h00;
      chg_ie_ff     <= 1'b0;
      ext_sel_ff    <= 1'b0;
      gie_ff        <= 1'b0;
      chg_flag_ff   <= 1'b0;
    end else begin
      chg_flag_ff <= nxt_chg_flag;
      if (wr_en) begin
        unique case (wr_idx)
          pgc_pkg::IDX_BUZZER_CTRL: begin
            tone_en_ff  <= wbyte[pgc_pkg::BIT_TONE_EN];
            tone_sel_ff <= wbyte[3:0];
          end
          pgc_pkg::IDX_INFRARED_CTRL: begin
            car_en_ff  <= wbyte[pgc_pkg::BIT_CARRIER_EN];
            car_57k_ff <= wbyte[pgc_pkg::BIT_CARRIER_57K];
            car_pol_ff <= wbyte[pgc_pkg::BIT_CARRIER_POL];
          end
          pgc_pkg::IDX_PORT_DATA:   data_ff       <= wbyte[5:0];                    // RL9
          pgc_pkg::IDX_PORT_DIR:    dir_ff        <= wbyte[5:0];                    // RL9
          pgc_pkg::IDX_PULL_HIGH:   pull_high_ff  <= wbyte[5:0];
          pgc_pkg::IDX_PULL_LOW:    pull_low_ff   <= wbyte[7:4];
          pgc_pkg::IDX_OPEN_DRAIN:  open_drain_ff <= wbyte[5:0];
          pgc_pkg::IDX_LEVEL_CHG:   chg_sel_ff    <= wbyte[5:0];
          pgc_pkg::IDX_IRQ_ENABLE:  chg_ie_ff     <= wbyte[pgc_pkg::BIT_PORT_CHG];
          pgc_pkg::IDX_POWER_CTRL:  ext_sel_ff    <= wbyte[pgc_pkg::BIT_EXT_IRQ_SEL];
          pgc_pkg::IDX_POWER_CTRL1: gie_ff        <= wbyte[pgc_pkg::BIT_GLOBAL_IRQ];
          default: begin
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tone generator: prescaler edge counter or timer bit
  logic [7:0] presc_cnt_ff;
  wire        presc_rise = i_prescaler_out && !presc_prev_ff;
  wire        nxt_tone   = tone_sel_ff[3] ? i_timer_val[tone_sel_ff[2:0]]            // RL2
                                          : presc_cnt_ff[tone_sel_ff[2:0]];          // RL1

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_cnt_ff <= 8'h00;
    end else if (presc_rise) begin
      presc_cnt_ff <= presc_cnt_ff + 8'h01;                                         // RL1
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Carrier generator on rising edges of the synchronised 4 MHz input
  logic [6:0] car_cnt_ff;
  logic       carrier_ff;
  wire        hosc_rise = hosc_s2_ff && !hosc_prev_ff && i_hosc_run;                // RL8
  wire [6:0]  car_half  = car_57k_ff ? pgc_pkg::HALF_57K : pgc_pkg::HALF_38K;      // RL5
  wire        car_wrap  = hosc_rise && (car_cnt_ff >= car_half - 7'h01);           // RL7

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      car_cnt_ff <= 7'h00;
      carrier_ff <= 1'b0;
    end else if (!car_en_ff) begin
      car_cnt_ff <= 7'h00;
      carrier_ff <= 1'b0;
    end else if (car_wrap) begin
      car_cnt_ff <= 7'h00;
      carrier_ff <= !carrier_ff;                                                   // RL7
    end else if (hosc_rise) begin
      car_cnt_ff <= car_cnt_ff + 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pad drive: special functions, open-drain and pulls
  wire       car_gate = car_pol_ff ? !data_ff[pgc_pkg::PIN_CARRIER]
                                   : data_ff[pgc_pkg::PIN_CARRIER];                 // RL6
  wire [5:0] drive_val;
  assign drive_val[0]   = data_ff[0];
  assign drive_val[1]   = car_en_ff ? (carrier_ff && car_gate) : data_ff[1];       // RL4 RL19
  assign drive_val[2]   = tone_en_ff ? nxt_tone : data_ff[2];                      // RL3
  assign drive_val[5:3] = data_ff[5:3];
  wire [5:0] od_eff  = open_drain_ff | (6'h01 << pgc_pkg::PIN_ALWAYS_OD);          // RL12 RL13
  wire [5:0] is_out  = ~dir_ff;                                                     // RL9
  pgc_pkg::pgc_pad_s nxt_pad;
  assign nxt_pad.out     = drive_val;
  assign nxt_pad.oe      = is_out & (~od_eff | ~drive_val);                        // RL12
  assign nxt_pad.pull_up = pull_high_ff & dir_ff;                                  // RL10
  assign nxt_pad.pull_dn = {2'h0, pull_low_ff} & dir_ff;                           // RL11

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad <= '0;
    end else begin
      o_pad <= nxt_pad;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_sel_change;
    chg_any && chg_mask != 6'h00;
  endsequence

  sequence s_no_event;
    !chg_any && !flag_clr;
  endsequence

  a_tone_divided: assert property (tone_en_ff && tone_sel_ff == 4'h0 && presc_rise && !wr_en |=> ##1 // RL1
    o_pad.out[2] != $past(o_pad.out[2])) else $error("tone did not follow prescaler");
  a_tone_source: assert property (tone_en_ff && !tone_sel_ff[3] |=>                 // RL1
    o_pad.out[2] == $past(presc_cnt_ff[tone_sel_ff[2:0]])) else $error("tone divider wrong");
  a_tone_timer: assert property (tone_en_ff && tone_sel_ff[3] |=>                   // RL2
    o_pad.out[2] == $past(i_timer_val[tone_sel_ff[2:0]])) else $error("tone timer bit wrong");
  a_tone_off: assert property (!tone_en_ff |=>                                      // RL3
    o_pad.out[2] == $past(data_ff[2])) else $error("tone present while disabled");
  a_carrier_off: assert property (!car_en_ff |=> !carrier_ff ##0                    // RL4
    o_pad.out[1] == $past(data_ff[1])) else $error("carrier present while disabled");
  a_carrier_period: assert property (car_en_ff && $past(car_en_ff) && $changed(carrier_ff) // RL5
    |-> $past(car_cnt_ff) == car_half - 7'h01) else $error("carrier half period wrong");
  a_carrier_pol: assert property (car_en_ff && (car_pol_ff == data_ff[1]) |=>       // RL6
    !o_pad.out[1]) else $error("carrier sent with wrong data polarity");
  a_hosc_stopped: assert property (car_en_ff && $past(!i_hosc_run) && $past(car_en_ff) |-> // RL8
    $stable(car_cnt_ff)) else $error("carrier counted without high oscillator");
  a_pin3_od: assert property (o_pad.oe[pgc_pkg::PIN_ALWAYS_OD] |->                  // RL13
    !o_pad.out[pgc_pkg::PIN_ALWAYS_OD]) else $error("pin 3 driven high");
  a_no_pd_high: assert property (o_pad.pull_dn[5:4] == 2'h0)                        // RL11
    else $error("pull-down on pin 5 or 4");
  a_change_sets: assert property (s_sel_change |=> chg_flag_ff)                     // RL15
    else $error("selected change did not set flag");
  a_flag_holds: assert property (chg_flag_ff ##0 s_no_event |=> chg_flag_ff)        // RL20
    else $error("change flag dropped without clear");
  a_irq_gate: assert property (chg_any && chg_ie_ff && gie_ff && !wr_en |=> o_irq)  // RL16
    else $error("enabled change did not raise interrupt");
  a_pin0_ext: assert property (ext_sel_ff && (pin_s2_ff[0] != pin_prev_ff[0])       // RL18
    && ((pin_s2_ff[5:1] ^ pin_prev_ff[5:1]) & chg_sel_ff[5:1]) == 5'h00 |-> !chg_any)
    else $error("pin 0 change detected under external interrupt");

endmodule

`default_nettype wire

// ### pgc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pgc_pin_model (
  input  wire logic              i_clk,
  input  wire pgc_pkg::pgc_pad_s i_pad,
  input  wire logic [5:0]        i_ext,
  input  wire logic [5:0]        i_ext_en,
  output logic [5:0]             o_pin
);
  logic [5:0] last_ff = 6'h00;
  // Pin level: own drive, then far side, then pulls; a floating pin wanders
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (i_pad.oe[i]) o_pin[i] = i_pad.out[i];
      else if (i_ext_en[i]) o_pin[i] = i_ext[i];
      else if (i_pad.pull_up[i]) o_pin[i] = 1'b1;
      else if (i_pad.pull_dn[i]) o_pin[i] = 1'b0;
      else o_pin[i] = ~last_ff[i];
    end
  end
  // Last level, so an undriven pin never settles
  always @(posedge i_clk) begin
    last_ff <= o_pin;
  end
endmodule
`default_nettype wire

// ### pgc_port_tone_ir_test.sv
`timescale 1ns/1ps
`default_nettype none
module pgc_port_tone_ir_test;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [5:0]        pin, ext = 6'h00, ext_en = 6'h00;
  logic              pre = 1'b0, pre_run = 1'b0, hosc = 1'b0, hosc_run = 1'b1;
  logic [7:0]        tmr = 8'h00;
  logic              ext_irq, irq, t2;
  pgc_pkg::pgc_pad_s pad;
  int                checks = 0, bad_count = 0, tcnt = 0, ccnt = 0;
  realtime           t_prev = 0, t_last = 0;

  pgc_port_tone_ir dut (
    .i_ref_clk(clk), .i_rst_n(rst_n),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .i_pin_in(pin), .o_pad(pad), .i_prescaler_out(pre),
    .i_timer_val(tmr), .i_hosc_clk(hosc), .i_hosc_run(hosc_run),
    .o_ext_irq_in(ext_irq), .o_irq(irq)
  );
  pgc_pin_model pins (.i_clk(clk), .i_pad(pad), .i_ext(ext), .i_ext_en(ext_en), .o_pin(pin));

  ////////////////////////////////////////////////////////////////////////////////
  // Clocks, prescaler stand-in and edge counters
  always #5 clk = ~clk;
  // 4 MHz source, edges kept clear of the rising clock edge
  always begin
    #123 hosc = ~hosc;
    #127 hosc = ~hosc;
  end
  always @(posedge clk) begin
    if (pre_run) pre <= ~pre;
    t2 <= pad.out[2];
    if (t2 !== pad.out[2]) tcnt++;
  end
  always @(pad.out[1]) begin
    t_prev = t_last;
    t_last = $realtime;
    ccnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, wait, verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus master: each channel held until its own ready
  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                    input logic [1:0] er = pgc_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      end
    end while ((s_axi_awvalid || s_axi_wvalid || s_axi_bready) && n < 200);
    if (n >= 200) begin
      bad_count++;
      results();
    end
  endtask
  task automatic rd(input logic [5:0] idx, input logic [1:0] er = pgc_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      end
    end while ((s_axi_arvalid || s_axi_rready) && n < 200);
    if (n >= 200) begin
      bad_count++;
      results();
    end
  endtask

  // Carrier run: half period in ns, or 0 for a quiet pin
  task automatic carr(input logic [7:0] ir, input int half);
    wr(pgc_pkg::IDX_INFRARED_CTRL, ir);
    w(10);
    @(negedge clk) ccnt = 0;
    w(3000);
    if (half == 0) chk("ir_quiet", 32'h0, 32'(ccnt));
    else chk("ir_half", 32'h1, {31'h0, ccnt >= 2 && t_last - t_prev > half - 20
                                 && t_last - t_prev < half + 20});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    w(3);
    rst_n <= 1'b1;
    rd(pgc_pkg::IDX_PORT_DIR);
    chk("dir_reset", 32'h3F, rv);
    rd(pgc_pkg::IDX_BUZZER_CTRL);
    chk("tone_ctrl_read", 32'h0, rv);
    rd(6'h3F, pgc_pkg::RESP_DECERR);
    wr(6'h3E, 8'hFF, pgc_pkg::RESP_DECERR);
    $display("test registers done");
    wr(pgc_pkg::IDX_PULL_HIGH, 8'h3F);
    wr(pgc_pkg::IDX_PULL_LOW, 8'hF0);
    w(3);
    chk("pull_up", 32'h3F, {26'h0, pad.pull_up});
    chk("pull_dn", 32'h0F, {26'h0, pad.pull_dn});
    wr(pgc_pkg::IDX_OPEN_DRAIN, 8'h01);
    wr(pgc_pkg::IDX_PORT_DATA, 8'h09);
    wr(pgc_pkg::IDX_PORT_DIR, 8'h00);
    w(3);
    chk("out", 32'h09, {26'h0, pad.out});
    chk("oe_high", 32'h36, {26'h0, pad.oe});
    chk("pull_up_out", 32'h0, {26'h0, pad.pull_up});
    wr(pgc_pkg::IDX_PORT_DATA, 8'h00);
    w(3);
    chk("oe_low", 32'h3F, {26'h0, pad.oe});
    $display("test pads done");
    tmr <= 8'hA5;
    for (int n = 0; n < 8; n++) begin
      wr(pgc_pkg::IDX_BUZZER_CTRL, 8'h88 + 8'(n));
      w(3);
      chk("tone_timer", {31'h0, tmr[n]}, {31'h0, pad.out[2]});
      tmr <= ~tmr;
      w(3);
      chk("tone_timer_inv", {31'h0, tmr[n]}, {31'h0, pad.out[2]});
    end
    pre_run <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      wr(pgc_pkg::IDX_BUZZER_CTRL, 8'h80 + 8'(n));
      w(4);
      @(negedge clk) tcnt = 0;
      repeat (256) @(negedge clk);
      chk("tone_div", 32'(128 >> n), 32'(tcnt));
    end
    pre_run <= 1'b0;
    tmr <= 8'h00;
    wr(pgc_pkg::IDX_BUZZER_CTRL, 8'h08);
    wr(pgc_pkg::IDX_PORT_DATA, 8'h04);
    w(3);
    chk("tone_off", 32'h1, {31'h0, pad.out[2]});
    $display("test tone done");
    wr(pgc_pkg::IDX_PORT_DATA, 8'h02);
    carr(8'h03, pgc_pkg::DIV_57K * 125);
    carr(8'h01, pgc_pkg::DIV_38K * 125);
    carr(8'h05, 0);
    wr(pgc_pkg::IDX_PORT_DATA, 8'h00);
    carr(8'h05, pgc_pkg::DIV_38K * 125);
    carr(8'h00, 0);
    hosc_run <= 1'b0;
    carr(8'h03, 0);
    hosc_run <= 1'b1;
    $display("test carrier done");
    wr(pgc_pkg::IDX_PORT_DIR, 8'h3F);
    ext_en <= 6'h3F;
    wr(pgc_pkg::IDX_LEVEL_CHG, 8'h02);
    wr(pgc_pkg::IDX_IRQ_FLAG, 8'h00);
    ext <= 6'h10;
    w(8);
    rd(pgc_pkg::IDX_IRQ_FLAG);
    chk("flag_unselected", 32'h0, rv);
    ext <= 6'h12;
    w(8);
    rd(pgc_pkg::IDX_IRQ_FLAG);
    chk("flag_selected", 32'h2, rv);
    wr(pgc_pkg::IDX_IRQ_ENABLE, 8'h02);
    chk("irq_no_global", 32'h0, {31'h0, irq});
    wr(pgc_pkg::IDX_POWER_CTRL1, 8'h80);
    chk("irq_on", 32'h1, {31'h0, irq});
    ext <= 6'h10;
    wr(pgc_pkg::IDX_IRQ_FLAG, 8'h02);
    rd(pgc_pkg::IDX_IRQ_FLAG);
    chk("flag_hold", 32'h2, rv);
    wr(pgc_pkg::IDX_IRQ_FLAG, 8'h00);
    rd(pgc_pkg::IDX_IRQ_FLAG);
    chk("flag_clear", 32'h0, rv);
    chk("irq_off", 32'h0, {31'h0, irq});
    wr(pgc_pkg::IDX_POWER_CTRL, 8'h40);
    wr(pgc_pkg::IDX_LEVEL_CHG, 8'h01);
    ext <= 6'h11;
    w(8);
    chk("ext_irq", 32'h1, {31'h0, ext_irq});
    rd(pgc_pkg::IDX_IRQ_FLAG);
    chk("flag_pin0", 32'h0, rv);
    rd(pgc_pkg::IDX_PORT_DATA);
    chk("pin_read", 32'h11, rv);
    $display("test change flag done");
    results();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
